// ==== common/osc_ctrl_pkg.sv ====
package osc_ctrl_pkg;

  // ----------------------------------------------------------
  // Register map and field layout
  // ----------------------------------------------------------
  localparam logic [11:0] OSC_CTRL_ADDR = 12'h000;
  localparam int FREQ_LSB = 4;
  localparam int EXT_RUN_BIT = 3;
  localparam int FAST_STB_BIT = 2;
  localparam int SLOW_STB_BIT = 1;
  localparam int CHOICE_BIT = 0;
  localparam logic [2:0] FREQ_RESET = 3'h6;
  localparam logic [2:0] FREQ_SLOW = 3'h0;
  localparam logic [2:0] FREQ_FAST = 3'h7;
  localparam logic CHOICE_RESET = 1'h0;

  // ----------------------------------------------------------
  // Timing
  // ----------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  // Longest gap between external clock edges before failure
  localparam int FAIL_TIME_NS = 100000;
  localparam int FAIL_CYCLES = FAIL_TIME_NS / CLK_PERIOD_NS;
  localparam int STARTUP_EDGES = 1024;
  // Oscillator edges seen before an internal source is stable
  localparam int WARM_EDGES = 8;

  // ----------------------------------------------------------
  // Fuse clock modes and start-up states
  // ----------------------------------------------------------
  typedef enum logic [2:0] {
    WATCH_CRYSTAL_MODE = 3'b000,
    MEDIUM_GAIN_CRYSTAL_MODE = 3'b001,
    HIGH_GAIN_CRYSTAL_MODE = 3'b010,
    EXT_LOGIC_CLK_MODE = 3'b011,
    INTERNAL_OSC_BOTH_IO_MODE = 3'b100,
    INTERNAL_OSC_CLKOUT_MODE = 3'b101,
    RESISTOR_CAP_PIN_IO_MODE = 3'b110,
    RESISTOR_CAP_CLKOUT_MODE = 3'b111
  } clock_mode_t;

  typedef enum logic [1:0] {
    SU_WAIT_TIMER = 2'b00,
    SU_COUNT = 2'b01,
    SU_DONE = 2'b10
  } startup_state_t;

endpackage

// ==== logic/osc_loss_watch.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// Loss-of-clock watchdog: too long without a rising edge
// ------------------------------------------------------------
module osc_loss_watch #(
  parameter int CYCLES = 20000
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic enable,
  input wire logic watched,
  output logic lost
);

  localparam int W = $clog2(CYCLES + 1);

  logic watched_prev_q;
  logic [W-1:0] idle_q;

  // Idle counter restarts on every rising edge, saturates
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      watched_prev_q <= 1'b0;
      idle_q <= '0;
    end else begin
      watched_prev_q <= watched;
      if (!enable || (watched && !watched_prev_q)) begin
        idle_q <= '0;
      end else if (idle_q != W'(CYCLES)) begin
        idle_q <= idle_q + 1'b1;
      end
    end
  end

  assign lost = enable && (idle_q == W'(CYCLES));

endmodule // osc_loss_watch

// ==== logic/osc_sync.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// Two-flop synchroniser, one chain per bit
// ------------------------------------------------------------
module osc_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_chain
      // First flop feeds only the second
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          meta_q[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_q[i] <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule // osc_sync

// ==== logic/system_clock_mode_select.sv ====
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps

// Summary of operation
// - Eight clock modes come from a three-bit fuse field, not a register.
// - Logic-clock mode clocks from the input pin; output pin becomes I/O.
// - Three crystal modes: watch, medium gain, high gain, driving both pins.
// - RC clock-out mode drives the clock divided by four on the output pin.
// - RC pin-I/O mode runs from RC and frees the output pin.
// - Internal clock-out mode drives clock/4 out and frees the input pin.
// - Internal both-I/O mode frees both oscillator pins.
// - Failure monitor detects lost external clock and falls back to internal.
// - Two internal oscillators: fast 8 MHz and slow 31 kHz.
// - Frequency field 111..001 gives 8 MHz..125 kHz, 000 slow; resets 110.
// - Running flag is 1 on the fuse-chosen clock, 0 on internal.
// - Running flag resets 0 with two-speed crystal or monitor, else 1.
// - Fast-stable flag reads 1 once fast oscillator is stable, resets 0.
// - Slow-stable flag reads 1 once slow oscillator is stable, resets 0.
// - Choice bit 1 selects internal clock; 0, its reset value, follows fuse.
// - Top register bit reads 0 and ignores writes.
// - Crystal modes without two-speed hold execution until 1024 oscillator cycles after the power-up timer.
// - Logic-clock mode disables the start-up counter, no added delay.
// - Fast oscillator enabled when frequency nonzero and choice or two-speed.
module system_clock_mode_select #(
  parameter int FAIL_CYCLES = osc_ctrl_pkg::FAIL_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] fuse_clock_mode,
  input wire logic fuse_two_speed_en,
  input wire logic fuse_fail_monitor_en,
  input wire logic power_up_timer_done,
  input wire logic sleep_wake,
  input wire logic clock_input_pin,
  input wire logic fast_internal_osc,
  input wire logic slow_internal_osc,
  output logic fast_osc_enable,
  output logic osc_amp_enable,
  output logic [1:0] osc_amp_gain,
  output logic clock_output_pin_o,
  output logic clock_output_pin_oe,
  output logic clock_input_pin_is_gpio,
  output logic clock_output_pin_is_gpio,
  output logic sys_clk_out,
  output logic hold_execution,
  output logic clock_failed
);

  // ----------------------------------------------------------
  // Fuse capture
  // ----------------------------------------------------------
  osc_ctrl_pkg::clock_mode_t mode_q;
  logic cfg_valid_q;
  logic two_speed_q;
  logic fail_mon_q;
  logic is_crystal;
  logic is_internal;

  // fuse mode capture
  // Straps are caught on the first edge after reset release
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cfg_valid_q <= 1'b0;
      mode_q <= osc_ctrl_pkg::EXT_LOGIC_CLK_MODE;
      two_speed_q <= 1'b0;
      fail_mon_q <= 1'b0;
    end else if (!cfg_valid_q) begin
      cfg_valid_q <= 1'b1;
      mode_q <= osc_ctrl_pkg::clock_mode_t'(fuse_clock_mode);
      two_speed_q <= fuse_two_speed_en;
      fail_mon_q <= fuse_fail_monitor_en;
    end
  end

  assign is_crystal = (mode_q == osc_ctrl_pkg::WATCH_CRYSTAL_MODE)
    || (mode_q == osc_ctrl_pkg::MEDIUM_GAIN_CRYSTAL_MODE)
    || (mode_q == osc_ctrl_pkg::HIGH_GAIN_CRYSTAL_MODE);
  assign is_internal = (mode_q == osc_ctrl_pkg::INTERNAL_OSC_BOTH_IO_MODE)
    || (mode_q == osc_ctrl_pkg::INTERNAL_OSC_CLKOUT_MODE);

  // ----------------------------------------------------------
  // Oscillator sampling
  // ----------------------------------------------------------
  logic ext_s;
  logic fast_s;
  logic slow_s;
  logic ext_prev_q;
  logic fast_prev_q;
  logic slow_prev_q;
  logic ext_rise;
  logic fast_rise;
  logic slow_rise;

  osc_sync #(
    .WIDTH(3)
  ) u_sync (
    .clock(clock),
    .reset(reset),
    .async_in({clock_input_pin, fast_internal_osc, slow_internal_osc}),
    .sync_out({ext_s, fast_s, slow_s})
  );

  // Edge history, read from the second synchroniser flop only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ext_prev_q <= 1'b0;
      fast_prev_q <= 1'b0;
      slow_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_s;
      fast_prev_q <= fast_s;
      slow_prev_q <= slow_s;
    end
  end

  assign ext_rise = ext_s && !ext_prev_q;
  assign fast_rise = fast_s && !fast_prev_q;
  assign slow_rise = slow_s && !slow_prev_q;

  // ----------------------------------------------------------
  // Register file
  // ----------------------------------------------------------
  logic [2:0] freq_q;
  logic choice_q;
  logic sel_fuse_q;
  logic [1:0] stable_q;
  logic fail_q;
  logic [31:0] prdata_q;
  logic hit;
  logic [7:0] ctrl_view;

  assign hit = (paddr == osc_ctrl_pkg::OSC_CTRL_ADDR);

  assign ctrl_view = {1'b0, freq_q, sel_fuse_q, stable_q, choice_q};

  // only frequency and choice are writable
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      freq_q <= osc_ctrl_pkg::FREQ_RESET;
      choice_q <= osc_ctrl_pkg::CHOICE_RESET;
    end else if (psel && penable && pwrite && hit) begin
      freq_q <= pwdata[osc_ctrl_pkg::FREQ_LSB +: 3];
      choice_q <= pwdata[osc_ctrl_pkg::CHOICE_BIT];
    end
  end

  // Read data settles in the setup cycle so the access needs no wait
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_q <= hit ? {24'h00_0000, ctrl_view} : 32'h0000_0000;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // ----------------------------------------------------------
  // Internal oscillators and postscaler
  // ----------------------------------------------------------
  logic [7:0] post_q;
  logic [2:0] post_idx;
  logic int_src;
  logic [1:0] osc_rise;
  logic [1:0] osc_on;
  logic [3:0] warm_q [2];

  // fast oscillator enable
  // Also kept on for internal modes and after a failover
  assign fast_osc_enable = cfg_valid_q && (freq_q != osc_ctrl_pkg::FREQ_SLOW)
    && (choice_q || two_speed_q || is_internal || fail_q);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      post_q <= 8'h00;
    end else if (!fast_osc_enable) begin
      post_q <= 8'h00;
    end else if (fast_rise) begin
      post_q <= post_q + 8'h01;
    end
  end

  // frequency code decode
  // Code 6 picks bit 0 (half rate) down to code 1 picking bit 5
  assign post_idx = 3'h6 - freq_q;
  assign int_src = (freq_q == osc_ctrl_pkg::FREQ_SLOW) ? slow_s
    : (freq_q == osc_ctrl_pkg::FREQ_FAST) ? fast_s
    : post_q[post_idx];

  assign osc_rise = {fast_rise, slow_rise};
  assign osc_on = {fast_osc_enable, 1'b1};

  // slow and fast stable flags
  // Stability is judged by counting edges of a running source
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_warm
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          warm_q[g] <= 4'h0;
          stable_q[g] <= 1'b0;
        end else if (!osc_on[g]) begin
          warm_q[g] <= 4'h0;
          stable_q[g] <= 1'b0;
        end else if (osc_rise[g] && !stable_q[g]) begin
          warm_q[g] <= warm_q[g] + 4'h1;
          stable_q[g] <= (warm_q[g] == 4'(osc_ctrl_pkg::WARM_EDGES - 1));
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------
  // Crystal start-up counter
  // ----------------------------------------------------------
  osc_ctrl_pkg::startup_state_t su_q;
  logic [10:0] su_cnt_q;

  // logic-clock and RC modes skip the count
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      su_q <= osc_ctrl_pkg::SU_WAIT_TIMER;
      su_cnt_q <= 11'h000;
    end else if (cfg_valid_q) begin
      case (su_q)
        osc_ctrl_pkg::SU_WAIT_TIMER: begin
          su_cnt_q <= 11'h000;
          if (!is_crystal) begin
            su_q <= osc_ctrl_pkg::SU_DONE;
          end else if (power_up_timer_done) begin
            su_q <= osc_ctrl_pkg::SU_COUNT;
          end
        end
        osc_ctrl_pkg::SU_COUNT: begin
          if (ext_rise) begin
            su_cnt_q <= su_cnt_q + 11'h001;
            if (su_cnt_q == 11'(osc_ctrl_pkg::STARTUP_EDGES - 1)) begin
              su_q <= osc_ctrl_pkg::SU_DONE;
            end
          end
        end
        osc_ctrl_pkg::SU_DONE: begin
          su_cnt_q <= 11'h000;
          if (sleep_wake && is_crystal) begin
            su_q <= osc_ctrl_pkg::SU_COUNT;
          end
        end
        default: begin
          su_q <= osc_ctrl_pkg::SU_WAIT_TIMER;
        end
      endcase
    end
  end

  // Two-speed start-up lets code run on the internal clock meanwhile
  assign hold_execution = !cfg_valid_q || ((su_q != osc_ctrl_pkg::SU_DONE)
    && !(two_speed_q && is_crystal));

  // ----------------------------------------------------------
  // Failure monitor
  // ----------------------------------------------------------
  logic lost;
  logic watch_en;

  // monitor external sources
  // A crystal still starting up is not counted as failed
  assign watch_en = cfg_valid_q && fail_mon_q && !is_internal
    && (su_q == osc_ctrl_pkg::SU_DONE);

  osc_loss_watch #(
    .CYCLES(FAIL_CYCLES)
  ) u_watch (
    .clock(clock),
    .reset(reset),
    .enable(watch_en),
    .watched(ext_s),
    .lost(lost)
  );

  // Failover stays until the next reset
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      fail_q <= 1'b0;
    end else if (lost) begin
      fail_q <= 1'b1;
    end
  end

  assign clock_failed = fail_q;

  // ----------------------------------------------------------
  // Glitch-free source switch
  // ----------------------------------------------------------
  logic fuse_src;
  logic want_fuse;
  logic old_src;
  logic new_src;
  logic sys_clk_q;
  logic sys_prev_q;
  logic div_q;
  logic clkout_q;
  logic switch_now;

  // external sources use the input pin
  // internal modes feed the internal source
  assign fuse_src = is_internal ? int_src : ext_s;

  assign want_fuse = !(choice_q || fail_q
    || (two_speed_q && is_crystal && (su_q != osc_ctrl_pkg::SU_DONE)));
  assign old_src = sel_fuse_q ? fuse_src : int_src;
  assign new_src = sel_fuse_q ? int_src : fuse_src;

  // A dead source may be stuck high, so failover waits on the new one only
  assign switch_now = (want_fuse != sel_fuse_q) && !new_src && (!old_src || fail_q);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sel_fuse_q <= 1'b1;
    end else if (!cfg_valid_q) begin
      sel_fuse_q <= !((fuse_two_speed_en && (fuse_clock_mode < 3'h3))
        || fuse_fail_monitor_en);
    end else if (switch_now) begin
      sel_fuse_q <= want_fuse;
    end
  end

  // System clock and clock-out divider
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sys_clk_q <= 1'b0;
      sys_prev_q <= 1'b0;
      div_q <= 1'b0;
      clkout_q <= 1'b0;
    end else begin
      // Low on a change edge, so a stuck-high old source leaves no runt
      sys_clk_q <= cfg_valid_q && old_src && !switch_now;
      sys_prev_q <= sys_clk_q;
      if (sys_clk_q && !sys_prev_q) begin
        div_q <= !div_q;
        if (div_q) begin
          clkout_q <= !clkout_q;
        end
      end
    end
  end

  assign sys_clk_out = sys_clk_q;

  // ----------------------------------------------------------
  // Pin ownership
  // ----------------------------------------------------------
  // RC and internal clock-out
  assign clock_output_pin_o = clkout_q;
  assign clock_output_pin_oe = cfg_valid_q
    && ((mode_q == osc_ctrl_pkg::RESISTOR_CAP_CLKOUT_MODE)
    || (mode_q == osc_ctrl_pkg::INTERNAL_OSC_CLKOUT_MODE));

  assign clock_output_pin_is_gpio = cfg_valid_q
    && ((mode_q == osc_ctrl_pkg::EXT_LOGIC_CLK_MODE)
    || (mode_q == osc_ctrl_pkg::RESISTOR_CAP_PIN_IO_MODE)
    || (mode_q == osc_ctrl_pkg::INTERNAL_OSC_BOTH_IO_MODE));
  assign clock_input_pin_is_gpio = cfg_valid_q && is_internal;

  assign osc_amp_enable = cfg_valid_q && is_crystal;
  assign osc_amp_gain = is_crystal ? mode_q[1:0] : 2'h0;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  property p_choice_write;
    psel && penable && pwrite && hit |=> choice_q == $past(pwdata[0]);
  endproperty
  a_choice_write: assert property (p_choice_write)
    else $error("choice bit did not take the written value");

  property p_top_bit;
    psel && !penable ##1 psel && penable |-> prdata[7] == 1'b0;
  endproperty
  a_top_bit: assert property (p_top_bit)
    else $error("top register bit read as one");

  property p_status_ro;
    psel && penable && pwrite && hit && cfg_valid_q
      |=> stable_q == $past(stable_q) || $past(osc_rise) != 2'h0;
  endproperty
  a_status_ro: assert property (p_status_ro)
    else $error("status flags moved on a bus write");

  property p_crystal_hold;
    su_q == osc_ctrl_pkg::SU_COUNT && !two_speed_q |-> hold_execution;
  endproperty
  a_crystal_hold: assert property (p_crystal_hold)
    else $error("execution released during crystal start-up");

  property p_ec_no_hold;
    $past(cfg_valid_q) && mode_q == osc_ctrl_pkg::EXT_LOGIC_CLK_MODE
      |-> !hold_execution;
  endproperty
  a_ec_no_hold: assert property (p_ec_no_hold)
    else $error("logic-clock mode held execution");

  property p_fast_en;
    cfg_valid_q && freq_q != 3'h0 && choice_q |-> fast_osc_enable;
  endproperty
  a_fast_en: assert property (p_fast_en)
    else $error("fast oscillator not enabled");

  property p_failover;
    fail_q && sel_fuse_q && !int_src |=> !sel_fuse_q;
  endproperty
  a_failover: assert property (p_failover)
    else $error("no fallback to internal after clock failure");

  property p_glitch_free;
    $past(cfg_valid_q) && $changed(sel_fuse_q) |-> !sys_clk_q;
  endproperty
  a_glitch_free: assert property (p_glitch_free)
    else $error("source changed while the clock was high");

  property p_clkout;
    cfg_valid_q && mode_q == osc_ctrl_pkg::RESISTOR_CAP_CLKOUT_MODE
      |-> clock_output_pin_oe;
  endproperty
  a_clkout: assert property (p_clkout)
    else $error("clock output pin not driven in RC clock-out mode");

  c_failover: cover property (fail_q && !sel_fuse_q);
  c_startup_done: cover property (su_q == osc_ctrl_pkg::SU_COUNT ##1 su_q == osc_ctrl_pkg::SU_DONE);
  c_to_internal: cover property ($fell(sel_fuse_q) && choice_q);

endmodule // system_clock_mode_select

// ==== verif/osc_source_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------
// Oscillator sources seen at the block's far side
// ----------------------------------------------------------
module osc_source_model #(
  parameter real EXT_HALF_NS = 20.0,
  parameter real FAST_HALF_NS = 62.5,
  parameter real SLOW_HALF_NS = 200.0
) (
  input wire logic ext_run,
  input wire logic fast_en,
  output logic clock_input_pin,
  output logic fast_internal_osc,
  output logic slow_internal_osc
);
  initial clock_input_pin = 1'b0;
  initial fast_internal_osc = 1'b0;
  initial slow_internal_osc = 1'b0;

  // External clock stands low when stopped, as a failed source would
  always begin
    #(EXT_HALF_NS);
    clock_input_pin = ext_run ? ~clock_input_pin : 1'b0;
  end

  // fast oscillator, only runs while enabled
  always begin
    #(FAST_HALF_NS);
    fast_internal_osc = fast_en ? ~fast_internal_osc : 1'b0;
  end

  // slow oscillator, scaled down so warm-up fits a short run
  always begin
    #(SLOW_HALF_NS);
    slow_internal_osc = ~slow_internal_osc;
  end
endmodule // osc_source_model

// ==== verif/system_clock_mode_select_tb.sv ====
`timescale 1ns/1ps

module system_clock_mode_select_tb;
  typedef struct packed {
    logic [2:0] mode;
    logic two_speed;
    logic [3:0] pins;
    logic [1:0] gain;
    logic hold;
    logic run;
  } row_t;

  // ----------------------------------------------------------
  // Signals
  // ----------------------------------------------------------
  logic clock = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [2:0] fuse_mode = 3'h3;
  logic two_speed = 1'b0, monitor = 1'b0, put_done = 1'b1, sleep_wake = 1'b0, ext_run = 1'b1;
  logic pready, pslverr, ext_pin, fast_osc, slow_osc, fast_osc_enable, osc_amp_enable;
  logic [1:0] osc_amp_gain;
  logic out_o, out_oe, in_gpio, out_gpio, sys_clk_out, hold_execution, clock_failed;
  int mismatches = 0, check_count = 0;
  // Pins are {in gpio, out gpio, amp on, out driven}
  row_t rows [9] = '{
    '{3'h0, 1'h0, 4'h2, 2'h0, 1'h1, 1'h1}, '{3'h1, 1'h0, 4'h2, 2'h1, 1'h1, 1'h1},
    '{3'h2, 1'h0, 4'h2, 2'h2, 1'h1, 1'h1}, '{3'h3, 1'h0, 4'h4, 2'h0, 1'h0, 1'h1},
    '{3'h4, 1'h0, 4'hc, 2'h0, 1'h0, 1'h1}, '{3'h5, 1'h0, 4'h9, 2'h0, 1'h0, 1'h1},
    '{3'h6, 1'h0, 4'h4, 2'h0, 1'h0, 1'h1}, '{3'h7, 1'h0, 4'h1, 2'h0, 1'h0, 1'h1},
    '{3'h0, 1'h1, 4'h2, 2'h0, 1'h0, 1'h0}};

  initial begin
    forever #2.5 clock = ~clock;
  end

  system_clock_mode_select #(.FAIL_CYCLES(64)) uut (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fuse_clock_mode(fuse_mode), .fuse_two_speed_en(two_speed), .fuse_fail_monitor_en(monitor),
    .power_up_timer_done(put_done), .sleep_wake(sleep_wake), .clock_input_pin(ext_pin),
    .fast_internal_osc(fast_osc), .slow_internal_osc(slow_osc), .fast_osc_enable(fast_osc_enable),
    .osc_amp_enable(osc_amp_enable), .osc_amp_gain(osc_amp_gain), .clock_output_pin_o(out_o),
    .clock_output_pin_oe(out_oe), .clock_input_pin_is_gpio(in_gpio),
    .clock_output_pin_is_gpio(out_gpio), .sys_clk_out(sys_clk_out),
    .hold_execution(hold_execution), .clock_failed(clock_failed));

  osc_source_model model (
    .ext_run(ext_run), .fast_en(fast_osc_enable), .clock_input_pin(ext_pin),
    .fast_internal_osc(fast_osc), .slow_internal_osc(slow_osc));

  // Whole-run limit, so a stuck source cannot hang the bench
  initial begin
    repeat (90000) @(posedge clock);
    mismatches++;
    $display("Error at %0t: run limit reached", $time);
    report_and_stop();
  end

  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // A spent wait bound ends the run at once
  task automatic bail(input int n, input int lim);
    if (n >= lim) begin
      mismatches++;
      $display("Error at %0t: wait timed out", $time);
      report_and_stop();
    end
  endtask

  // Fuses are captured just after reset, so every mode change resets
  task automatic restart(input logic [2:0] m, input logic ts, input logic mon);
    @(posedge clock);
    fuse_mode <= m;
    two_speed <= ts;
    monitor <= mon;
    reset <= 1'b1;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    bail(n, 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic e;
    int n;
    int m;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      restart(rows[i].mode, rows[i].two_speed, 1'b0);
      repeat (4) @(posedge clock);
      chk({in_gpio, out_gpio, osc_amp_enable, out_oe}, rows[i].pins, "pin use");
      chk(osc_amp_gain & {2{osc_amp_enable}}, rows[i].gain, "amp gain");
      chk(hold_execution, rows[i].hold, "hold");
      apb(1'b0, 12'h000, 32'h0, r, e);
      chk(r & 32'hffff_fff9, {24'h0, 4'h6, rows[i].run, 3'h0}, "reset value");
      $display("Mode row %0d done", i);
    end

    // Register writes, read-only bits and frequency codes
    restart(3'h3, 1'b0, 1'b0);
    apb(1'b1, 12'h000, 32'h0000_00ff, r, e);
    @(posedge clock);
    chk(fast_osc_enable, 1'b1, "fast enable");
    repeat (800) @(posedge clock);
    apb(1'b0, 12'h000, 32'h0, r, e);
    chk(r, 32'h0000_0077, "internal run");
    apb(1'b1, 12'h004, 32'h0, r, e);
    chk(e, 1'b1, "unmapped write err");
    apb(1'b0, 12'h004, 32'h0, r, e);
    chk({e, r}, {1'b1, 32'h0}, "unmapped read");
    apb(1'b0, 12'h000, 32'h0, r, e);
    chk(r, 32'h0000_0077, "untouched");
    apb(1'b1, 12'h000, 32'h0000_0001, r, e);
    apb(1'b0, 12'h000, 32'h0, r, e);
    chk({fast_osc_enable, r & 32'hffff_fff1}, {1'b0, 32'h1}, "slow code");
    $display("Register test done");

    // Crystal start-up count and restart on wake
    restart(3'h0, 1'b0, 1'b0);
    repeat (1000) @(posedge ext_pin);
    chk(hold_execution, 1'b1, "held early");
    n = 0;
    while (hold_execution !== 1'b0 && n < 200) begin
      @(posedge ext_pin);
      n++;
    end
    bail(n, 200);
    chk(n < 40, 1'b1, "hold release");
    @(posedge clock);
    sleep_wake <= 1'b1;
    @(posedge clock);
    sleep_wake <= 1'b0;
    repeat (4) @(posedge clock);
    chk(hold_execution, 1'b1, "held on wake");
    $display("Start-up test done");

    // Clock out at a quarter of the oscillation rate
    restart(3'h7, 1'b0, 1'b0);
    repeat (20) @(posedge ext_pin);
    n = 0;
    m = 0;
    fork
      repeat (80) @(posedge ext_pin);
      forever begin
        @(posedge out_o);
        n++;
      end
      forever begin
        @(posedge sys_clk_out);
        m++;
      end
    join_any
    disable fork;
    chk(n >= 19 && n <= 21, 1'b1, "clock out rate");
    chk(m >= 79 && m <= 81, 1'b1, "system clock rate");
    $display("Clock out test done");

    // Lost external clock falls back to internal
    restart(3'h3, 1'b0, 1'b1);
    repeat (500) @(posedge clock);
    chk(clock_failed, 1'b0, "no false alarm");
    ext_run <= 1'b0;
    n = 0;
    while (clock_failed !== 1'b1 && n < 200) begin
      @(posedge clock);
      n++;
    end
    bail(n, 200);
    chk(clock_failed, 1'b1, "failure flag");
    repeat (20) @(posedge clock);
    apb(1'b0, 12'h000, 32'h0, r, e);
    chk(r & 32'h0000_0008, 32'h0, "failover flag");
    $display("Failure test done");
    report_and_stop();
  end
endmodule // system_clock_mode_select_tb
